// ---- core/clk_sel_pkg.sv ----
`default_nettype none
package clk_sel_pkg;

  // Source select codes
  localparam logic [1:0] SEL_WAKEUP = 2'h0;
  localparam logic [1:0] SEL_RESERVED = 2'h1;
  localparam logic [1:0] SEL_LOOP_OR_PRESCALE = 2'h2;
  localparam logic [1:0] SEL_DIRECT = 2'h3;

  // Field widths
  localparam int PRESCALE_W = 10;
  localparam int LOOP_P_W = 4;
  localparam int LOOP_N_W = 7;
  localparam int LOOP_K2_W = 7;
  localparam int PERIOD_W = 16;
  localparam int ACC_W = PERIOD_W + LOOP_P_W + LOOP_K2_W + 2;

  // Synchroniser source indices
  localparam int SRC_COUNT = 4;
  localparam int SRC_DIRECT = 0;
  localparam int SRC_CRYSTAL = 1;
  localparam int SRC_INTERNAL = 2;
  localparam int SRC_WAKEUP = 3;

  // Reset values
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 10'h000;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hFFFF;
  localparam logic [ACC_W-1:0] ACC_RST = 29'h00000000;

  typedef enum logic [2:0]
  {
    MODE_STOP = 3'b000,
    MODE_WAKEUP = 3'b001,
    MODE_DIRECT = 3'b010,
    MODE_PRESCALE = 3'b011,
    MODE_LOOP = 3'b100
  } mode_e;

  typedef struct packed
  {
    logic [1:0] clock_source_select;
    logic vco_bypass;
    logic prescale_from_internal;
    logic [PRESCALE_W-1:0] output_prescaler_value;
    logic [LOOP_P_W-1:0] loop_input_divider;
    logic [LOOP_N_W-1:0] loop_feedback_multiplier;
    logic [LOOP_K2_W-1:0] loop_output_divider;
  } clock_cfg_s;

endpackage : clk_sel_pkg
`default_nettype wire

// ---- core/clk_src_sync.sv ----
`default_nettype none
module clk_src_sync
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] level
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_src
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // A change is accepted only once the second and third stages agree
      wire agree = (s2_r == s3_r);
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end
        else if (ce)
        begin
          s1_r <= raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (agree)
            lvl_r <= s3_r;
        end
      end
      assign level[g] = lvl_r;
    end
  endgenerate

endmodule : clk_src_sync
`default_nettype wire

// ---- core/system_clock_source_select.sv ----
// Operation
// - Select code 11 passes the direct clock input to the system clock unchanged.
// - Prescaler mode from the crystal pin with factor 1 behaves like direct drive.
// - Select code 10 with vco bypass set picks prescaler mode from crystal or internal source.
// - In prescaler mode the source is divided by the prescaler field plus one.
// - With factor 1 the system clock follows the source level and duty cycle.
// - The largest prescaler factor is 1024.
// - Select code 10 with vco bypass clear runs the system clock from the loop.
// - Loop output is input times (feedback+1) over (input div+1)(output div+1).
// - Select code 00 runs the system clock from the wakeup clock.
`default_nettype none
module system_clock_source_select
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Configuration
  input wire clk_sel_pkg::clock_cfg_s cfg,
  // Clock sources
  input wire logic direct_clock_input,
  input wire logic crystal_input_pin,
  input wire logic internal_clock_in,
  input wire logic wakeup_clock_in,
  // Result
  output logic system_clock,
  output clk_sel_pkg::mode_e active_mode
);

  function automatic clk_sel_pkg::mode_e decode_mode(input logic [1:0] sel, input logic byp);
    case (sel)
      clk_sel_pkg::SEL_DIRECT: decode_mode = clk_sel_pkg::MODE_DIRECT;
      clk_sel_pkg::SEL_LOOP_OR_PRESCALE:
        decode_mode = byp ? clk_sel_pkg::MODE_PRESCALE : clk_sel_pkg::MODE_LOOP;
      clk_sel_pkg::SEL_WAKEUP: decode_mode = clk_sel_pkg::MODE_WAKEUP;
      default: decode_mode = clk_sel_pkg::MODE_STOP;
    endcase
  endfunction : decode_mode

  // Reset release through two flops
  logic rst_a_r;
  logic rst_b_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end
  wire srst_n = rst_b_r;

  // Source sampling
  logic [clk_sel_pkg::SRC_COUNT-1:0] src_lvl;
  clk_src_sync #(.WIDTH(clk_sel_pkg::SRC_COUNT)) u_sync
  (
    .clk(clk),
    .rst_n(srst_n),
    .ce(ce),
    .raw({wakeup_clock_in, internal_clock_in, crystal_input_pin, direct_clock_input}),
    .level(src_lvl)
  );

  wire clk_sel_pkg::mode_e mode_w = decode_mode(cfg.clock_source_select, cfg.vco_bypass);
  // Oscillator feeding both prescaler and loop
  wire osc_lvl = cfg.prescale_from_internal ? src_lvl[clk_sel_pkg::SRC_INTERNAL]
                                            : src_lvl[clk_sel_pkg::SRC_CRYSTAL];
  logic osc_prev_r;
  wire osc_rise = osc_lvl & ~osc_prev_r;

  // Prescaler: count source periods, high for the first half rounded up
  logic [clk_sel_pkg::PRESCALE_W-1:0] div_cnt_r;
  wire [clk_sel_pkg::PRESCALE_W-1:0] div_val = cfg.output_prescaler_value;
  wire div_wrap = (div_cnt_r >= div_val);
  wire [clk_sel_pkg::PRESCALE_W-1:0] div_cnt_nxt =
    div_wrap ? clk_sel_pkg::PRESCALE_RST : div_cnt_r + 10'h001;
  wire [clk_sel_pkg::PRESCALE_W:0] div_half = ({1'b0, div_val} + 11'h002) >> 1;
  // Odd factors keep the longer half high rather than add a half-period counter
  wire div_hi = ({1'b0, div_cnt_r} < div_half);
  wire div_one = (div_val == clk_sel_pkg::PRESCALE_RST);
  wire pre_clk = div_one ? osc_lvl : div_hi;

  // Loop: measured input period drives a digital oscillator
  logic [clk_sel_pkg::PERIOD_W-1:0] per_cnt_r;
  logic [clk_sel_pkg::PERIOD_W-1:0] period_r;
  logic [clk_sel_pkg::ACC_W-1:0] acc_r;
  logic loop_clk_r;
  wire [clk_sel_pkg::LOOP_P_W:0] p_fac = {1'b0, cfg.loop_input_divider} + 5'h01;
  wire [clk_sel_pkg::LOOP_N_W:0] n_fac = {1'b0, cfg.loop_feedback_multiplier} + 8'h01;
  wire [clk_sel_pkg::LOOP_K2_W:0] k2_fac = {1'b0, cfg.loop_output_divider} + 8'h01;
  // Full output period in units of clk cycles times the multiplier
  wire [clk_sel_pkg::ACC_W-1:0] loop_lim =
    clk_sel_pkg::ACC_W'(period_r) * clk_sel_pkg::ACC_W'(p_fac) * clk_sel_pkg::ACC_W'(k2_fac);
  wire [clk_sel_pkg::ACC_W-1:0] loop_step = clk_sel_pkg::ACC_W'({n_fac, 1'b0});
  wire [clk_sel_pkg::ACC_W-1:0] acc_sum = acc_r + loop_step;
  // At most one toggle per clk, so the output saturates at half the sampling rate
  wire loop_tog = (period_r != clk_sel_pkg::PERIOD_RST) && (acc_sum >= loop_lim);
  wire [clk_sel_pkg::ACC_W-1:0] acc_nxt = loop_tog ? acc_sum - loop_lim : acc_sum;
  wire [clk_sel_pkg::PERIOD_W-1:0] per_cnt_nxt =
    osc_rise ? 16'h0001 : (per_cnt_r == clk_sel_pkg::PERIOD_MAX) ? per_cnt_r : per_cnt_r + 16'h0001;

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      osc_prev_r <= 1'b0;
      div_cnt_r <= clk_sel_pkg::PRESCALE_RST;
      per_cnt_r <= clk_sel_pkg::PERIOD_RST;
      period_r <= clk_sel_pkg::PERIOD_RST;
      acc_r <= clk_sel_pkg::ACC_RST;
      loop_clk_r <= 1'b0;
    end
    else if (ce)
    begin
      osc_prev_r <= osc_lvl;
      if (osc_rise)
        div_cnt_r <= div_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      if (osc_rise)
        period_r <= per_cnt_r;
      if (mode_w == clk_sel_pkg::MODE_LOOP)
      begin
        acc_r <= acc_nxt;
        if (loop_tog)
          loop_clk_r <= ~loop_clk_r;
      end
    end
  end

  // Output selection
  logic sys_nxt;
  always_comb
  begin
    case (mode_w)
      clk_sel_pkg::MODE_DIRECT: sys_nxt = src_lvl[clk_sel_pkg::SRC_DIRECT];
      clk_sel_pkg::MODE_PRESCALE: sys_nxt = pre_clk;
      clk_sel_pkg::MODE_LOOP: sys_nxt = loop_clk_r;
      clk_sel_pkg::MODE_WAKEUP: sys_nxt = src_lvl[clk_sel_pkg::SRC_WAKEUP];
      default: sys_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      system_clock <= 1'b0;
      active_mode <= clk_sel_pkg::MODE_STOP;
    end
    else if (ce)
    begin
      system_clock <= sys_nxt;
      active_mode <= mode_w;
    end
  end

endmodule : system_clock_source_select
`default_nettype wire

// ---- verif/clk_sel_checker.sv ----
`default_nettype none
module clk_sel_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Watched ports
  input wire clk_sel_pkg::clock_cfg_s cfg,
  input wire logic direct_clock_input,
  input wire logic crystal_input_pin,
  input wire logic internal_clock_in,
  input wire logic wakeup_clock_in,
  input wire logic system_clock,
  input wire clk_sel_pkg::mode_e active_mode
);
  // Wait out the reset release flops
  logic [2:0] up_r;
  wire logic ok = up_r == 3'h7 && ce;
  wire logic [1:0] sel = cfg.clock_source_select;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      up_r <= 3'h0;
    else if (up_r != 3'h7)
      up_r <= up_r + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dir;
    ok && sel == 2'h3 |=> active_mode == clk_sel_pkg::MODE_DIRECT;
  endproperty
  a_dir: assert property (p_dir) else $error("direct mode missed");
  property p_pre;
    ok && sel == 2'h2 && cfg.vco_bypass |=> active_mode == clk_sel_pkg::MODE_PRESCALE;
  endproperty
  a_pre: assert property (p_pre) else $error("prescale mode missed");
  property p_loop;
    ok && sel == 2'h2 && !cfg.vco_bypass |=> active_mode == clk_sel_pkg::MODE_LOOP;
  endproperty
  a_loop: assert property (p_loop) else $error("loop mode missed");
  property p_wake;
    ok && sel == 2'h0 |=> active_mode == clk_sel_pkg::MODE_WAKEUP;
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup mode missed");
  property p_dfol;
    (ok && active_mode == clk_sel_pkg::MODE_DIRECT)[*6]
      |-> system_clock == $past(direct_clock_input, 5);
  endproperty
  a_dfol: assert property (p_dfol) else $error("direct clock not followed");
  property p_xfol;
    (ok && active_mode == clk_sel_pkg::MODE_PRESCALE && cfg.output_prescaler_value == 10'h000
      && !cfg.prescale_from_internal)[*6] |-> system_clock == $past(crystal_input_pin, 5);
  endproperty
  a_xfol: assert property (p_xfol) else $error("factor one not followed");
  property p_wfol;
    (ok && active_mode == clk_sel_pkg::MODE_WAKEUP)[*6]
      |-> system_clock == $past(wakeup_clock_in, 5);
  endproperty
  a_wfol: assert property (p_wfol) else $error("wakeup clock not followed");
  property p_stop;
    (ok && active_mode == clk_sel_pkg::MODE_STOP)[*2] |-> !system_clock;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped clock moved");
  c_dir: cover property (active_mode == clk_sel_pkg::MODE_DIRECT && system_clock);
  c_pre: cover property (active_mode == clk_sel_pkg::MODE_PRESCALE && system_clock);
  c_loop: cover property (active_mode == clk_sel_pkg::MODE_LOOP && system_clock);
endmodule : clk_sel_checker
bind system_clock_source_select clk_sel_checker i_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .cfg(cfg), .direct_clock_input(direct_clock_input), .crystal_input_pin(crystal_input_pin),
  .internal_clock_in(internal_clock_in), .wakeup_clock_in(wakeup_clock_in),
  .system_clock(system_clock), .active_mode(active_mode));
`default_nettype wire

// ---- verif/system_clock_source_select_tb_top.sv ----
`default_nettype none
module system_clock_source_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic d_src = 1'b0;
  logic x_src = 1'b0;
  logic i_src = 1'b0;
  logic w_src = 1'b0;
  logic sys;
  clk_sel_pkg::clock_cfg_s cfg = '0;
  clk_sel_pkg::mode_e mode;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  system_clock_source_select i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cfg(cfg),
    .direct_clock_input(d_src), .crystal_input_pin(x_src), .internal_clock_in(i_src),
    .wakeup_clock_in(w_src), .system_clock(sys), .active_mode(mode));
  initial
    forever #2 clk = ~clk;
  // Sources kept slow enough for the synchroniser
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    d_src <= cyc % 10 < 5;
    x_src <= cyc % 12 < 6;
    i_src <= cyc % 16 < 8;
    w_src <= cyc % 40 < 20;
    if (cyc == 80000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk
  task automatic setc(logic [1:0] s, logic b, logic i, logic [9:0] v, logic [3:0] p,
    logic [6:0] n, logic [6:0] k);
    @(posedge clk);
    cfg <= '{s, b, i, v, p, n, k};
    repeat (40) @(posedge clk);
  endtask : setc
  // Rise to rise, so duty cycle does not matter
  task automatic meas(string what, int exp);
    int n;
    int p;
    logic prv;
    n = 0;
    p = 0;
    #1;
    prv = sys;
    while (n < 2)
    begin
      @(posedge clk);
      #1;
      if (sys === 1'b1 && prv === 1'b0)
        n++;
      if (n == 1)
        p++;
      prv = sys;
    end
    chk(what, p, exp);
  endtask : meas
  task automatic t_direct;
    setc(2'h3, 1'b0, 1'b0, 10'h000, 4'h0, 7'h00, 7'h00);
    chk("mode", mode, clk_sel_pkg::MODE_DIRECT);
    meas("direct period", 10);
    $display("direct done");
  endtask : t_direct
  task automatic t_presc;
    int vals[5] = '{0, 1, 2, 4, 1023};
    foreach (vals[j])
    begin
      setc(2'h2, 1'b1, 1'b0, vals[j][9:0], 4'h0, 7'h00, 7'h00);
      chk("mode", mode, clk_sel_pkg::MODE_PRESCALE);
      meas("crystal period", (vals[j] + 1) * 12);
    end
    setc(2'h2, 1'b1, 1'b1, 10'h002, 4'h0, 7'h00, 7'h00);
    meas("internal period", 48);
    $display("prescale done");
  endtask : t_presc
  task automatic t_loop;
    setc(2'h2, 1'b0, 1'b1, 10'h000, 4'h0, 7'h03, 7'h00);
    chk("mode", mode, clk_sel_pkg::MODE_LOOP);
    meas("loop period", 4);
    setc(2'h2, 1'b0, 1'b0, 10'h000, 4'h1, 7'h07, 7'h01);
    meas("loop period", 6);
    $display("loop done");
  endtask : t_loop
  task automatic t_wake_stop;
    int h;
    h = 0;
    setc(2'h0, 1'b0, 1'b0, 10'h000, 4'h0, 7'h00, 7'h00);
    chk("mode", mode, clk_sel_pkg::MODE_WAKEUP);
    meas("wakeup period", 40);
    // Undocumented code must not leak any source
    setc(2'h1, 1'b0, 1'b0, 10'h000, 4'h0, 7'h00, 7'h00);
    chk("mode", mode, clk_sel_pkg::MODE_STOP);
    repeat (50)
    begin
      @(posedge clk);
      #1;
      if (sys !== 1'b0)
        h++;
    end
    chk("stopped highs", h, 0);
    $display("wakeup and stop done");
  endtask : t_wake_stop
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_direct();
    t_presc();
    t_loop();
    t_wake_stop();
    complete_run();
  end
endmodule : system_clock_source_select_tb_top
`default_nettype wire
